// *** src/dsci_pkg.sv ***
// constants, encodings and helpers for the dual serial command interface
// assumes a 10 MHz core clock; both link sides live in dsci_top
package dsci_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_FREQ_KHZ = 10000; // core clock rate
    localparam int unsigned EE_STORE_US = 18000; // eeprom store time, microseconds
    // least lock time, rounded up to whole cycles
    localparam int unsigned EE_LOCK_CYCLES = (EE_STORE_US * CLK_FREQ_KHZ + 999) / 1000;

    // ----------------------------------------------------------------
    // command word layout
    // ----------------------------------------------------------------
    localparam int unsigned WORD_W = 16; // command word width
    localparam int unsigned CODE_MSB = 15; // control field top bit
    localparam int unsigned CODE_LSB = 12; // control field low bit
    localparam logic [3:0] CODE_READBACK = 4'h3; // readback request
    localparam logic [3:0] CODE_COPY = 4'h7; // copy, d0 set means store to eeprom
    localparam logic [3:0] CODE_EE_WRITE = 4'h8; // direct eeprom write
    localparam logic [15:0] WORD_RST = 16'hFFFF; // idle/readback word after reset

    // ----------------------------------------------------------------
    // frame edge counter
    // ----------------------------------------------------------------
    localparam int unsigned CNT_W = 6; // edge counter width
    localparam logic [5:0] CNT_MAX = 6'h3F; // saturation value
    localparam logic [5:0] CNT_ONE = 6'h01; // first edge of a frame
    localparam logic [5:0] CNT_16 = 6'h10; // single device frame
    localparam logic [5:0] CNT_24 = 6'h18; // three byte frame
    localparam logic [5:0] CNT_32 = 6'h20; // two device chain frame

    // ----------------------------------------------------------------
    // two-wire slave
    // ----------------------------------------------------------------
    localparam logic [3:0] BIT_LAST = 4'h7; // eighth data bit index
    localparam logic [3:0] BIT_ACK = 4'h8; // acknowledge slot index
    localparam logic [7:0] BYTE_IDLE = 8'hFF; // released data byte
    localparam logic [2:0] ADDR_TOP = 3'h2; // fixed upper address bits
    // strap level codes as delivered by the pad detector
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_OPEN = 2'h1;
    localparam logic [1:0] STRAP_HIGH = 2'h2;
    // address field per strap level
    localparam logic [1:0] FIELD_HIGH = 2'h0;
    localparam logic [1:0] FIELD_OPEN = 2'h2;
    localparam logic [1:0] FIELD_LOW = 2'h3;

    // two-wire slave states
    typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_WRITE, I2C_READ} dsci_i2c_e;

    // two-bit address field from one strap level
    function automatic logic [1:0] strap_field(input logic [1:0] lvl);
        strap_field = (lvl == STRAP_HIGH) ? FIELD_HIGH :
                      (lvl == STRAP_OPEN) ? FIELD_OPEN : FIELD_LOW;
    endfunction

endpackage

// *** src/dsci_top.sv ***
// dual serial command front end: four-wire shift link and two-wire slave
// assumes clk at 10 MHz; spi_clk is the host's shift clock and may stop
// between frames; strap and two-wire pins are asynchronous to clk
module dsci_top #(
    parameter int unsigned EE_LOCK_CYCLES = dsci_pkg::EE_LOCK_CYCLES
) (
    // core clock and reset
    input wire logic clk,
    input wire logic nrst,
    // straps
    input wire logic link_select_strap,
    input wire logic [1:0] address_strap_lo,
    input wire logic [1:0] address_strap_hi,
    // four-wire link
    input wire logic spi_clk,
    input wire logic frame_sel_n,
    input wire logic serial_in,
    output logic serial_out_od,
    output logic serial_out_oe_n,
    // two-wire link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // command decoder side
    output logic [15:0] cmd_word,
    output logic cmd_valid,
    output logic eeprom_lock,
    input wire logic [15:0] resp_word,
    input wire logic resp_valid
);

    localparam int unsigned LW = $clog2(EE_LOCK_CYCLES + 1); // lock counter width

    // ----------------------------------------------------------------
    // state types
    // ----------------------------------------------------------------
    // core clock domain
    typedef struct packed {
        logic [1:0] mode_sync; // strap synchroniser
        logic [1:0] alo_s1; // address strap stage one
        logic [1:0] alo_s2;
        logic [1:0] ahi_s1;
        logic [1:0] ahi_s2;
        logic spi_mode; // four-wire link selected
        logic [6:0] own_addr; // strapped slave address
        logic [1:0] cs_sync; // frame select synchroniser
        logic cs_prev;
        logic [1:0] scl_sync; // two-wire synchronisers
        logic [1:0] sda_sync;
        logic scl_prev;
        logic sda_prev;
        dsci_pkg::dsci_i2c_e ist; // two-wire state
        logic [3:0] bitcnt; // bit slot in byte
        logic [7:0] rx; // received byte
        logic rw; // direction of transaction
        logic mack; // host acked last byte
        logic half; // high byte held
        logic [7:0] hi_byte; // held high byte
        logic [7:0] tx; // byte being sent
        logic tx_lo; // low byte in flight
        logic serve; // read returns a real result
        logic sda_out; // open-drain level, always low
        logic sda_oe_n; // low while pulling data low
        logic [15:0] cmd_word; // delivered command
        logic cmd_valid; // one-cycle delivery pulse
        logic [15:0] rb_word; // readback result
        logic rb_pending; // result not yet returned
        logic lock; // eeprom store in progress
        logic [LW-1:0] lock_cnt; // cycles left in store
    } dsci_clk_s;

    // shift clock domain, falling edge, survives between frames
    typedef struct packed {
        logic [16:0] shift; // input shift chain plus output head
        logic [5:0] count; // falling edges this frame
        logic rb_frame; // frame carries a readback word out
    } dsci_fall_s;

    // shift clock domain, rising edge, cleared by frame end
    typedef struct packed {
        logic od_level; // open-drain level, always low
        logic oe_n; // low while pulling output low
    } dsci_rise_s;

    dsci_clk_s c_reg;
    dsci_clk_s c_next;
    dsci_fall_s f_reg;
    dsci_fall_s f_next;
    dsci_rise_s r_reg;
    dsci_rise_s r_next;
    logic fresh_reg; // no edge seen yet this frame
    logic frame_rst_n; // frame, mode or global reset

    // ----------------------------------------------------------------
    // four-wire link, shift clock domain
    // ----------------------------------------------------------------
    // frame end, two-wire mode or reset clear the per-frame state
    assign frame_rst_n = nrst & ~frame_sel_n & ~link_select_strap;

    // falling edge: shift in, count edges, load readback at first edge
    always_comb begin
        f_next = f_reg;
        if (!frame_sel_n && !link_select_strap) begin
            if (fresh_reg) begin
                // readback word is static here: set before this frame began
                f_next.rb_frame = c_reg.rb_pending;
                f_next.shift = c_reg.rb_pending ? {c_reg.rb_word, serial_in}
                                                : {f_reg.shift[15:0], serial_in};
                f_next.count = dsci_pkg::CNT_ONE;
            end else begin
                f_next.shift = {f_reg.shift[15:0], serial_in};
                if (f_reg.count != dsci_pkg::CNT_MAX) begin
                    f_next.count = f_reg.count + 6'h01;
                end
            end
        end
    end

    // falling edge registers, kept across the idle gap
    always_ff @(negedge spi_clk or negedge nrst) begin
        if (!nrst) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    // first-edge marker, set by the frame's own end
    always_ff @(negedge spi_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    // rising edge: present next output bit, sixteen bits behind the input
    always_comb begin
        r_next = r_reg;
        r_next.od_level = 1'b0;
        // head bit 16 only while a readback word leaves; else chain bit 15
        r_next.oe_n = f_reg.rb_frame ? f_reg.shift[16] : f_reg.shift[15];
    end

    // rising edge registers, released whenever the frame is high
    always_ff @(posedge spi_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            r_reg <= '{od_level: 1'b0, oe_n: 1'b1};
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // core clock domain
    // ----------------------------------------------------------------
    always_comb begin
        logic cs_rise; // frame end seen
        logic scl_rise;
        logic scl_fall;
        logic i2c_start;
        logic i2c_stop;
        logic take; // deliver a command word
        logic [15:0] word; // word to deliver
        cs_rise = 1'b0;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        i2c_start = 1'b0;
        i2c_stop = 1'b0;
        take = 1'b0;
        word = '0;
        c_next = c_reg;
        c_next.cmd_valid = 1'b0;
        c_next.sda_out = 1'b0;

        // synchronisers and strap capture
        c_next.mode_sync = {c_reg.mode_sync[0], link_select_strap};
        c_next.alo_s1 = address_strap_lo;
        c_next.alo_s2 = c_reg.alo_s1;
        c_next.ahi_s1 = address_strap_hi;
        c_next.ahi_s2 = c_reg.ahi_s1;
        c_next.spi_mode = ~c_reg.mode_sync[1];
        c_next.own_addr = {dsci_pkg::ADDR_TOP, dsci_pkg::strap_field(c_reg.ahi_s2),
                           dsci_pkg::strap_field(c_reg.alo_s2)};
        c_next.cs_sync = {c_reg.cs_sync[0], frame_sel_n};
        c_next.cs_prev = c_reg.cs_sync[1];
        c_next.scl_sync = {c_reg.scl_sync[0], scl_in};
        c_next.sda_sync = {c_reg.sda_sync[0], sda_in};
        c_next.scl_prev = c_reg.scl_sync[1];
        c_next.sda_prev = c_reg.sda_sync[1];

        // eeprom store timer
        if (c_reg.lock) begin
            if (c_reg.lock_cnt == '0) begin
                c_next.lock = 1'b0;
            end else begin
                c_next.lock_cnt = c_reg.lock_cnt - LW'(1);
            end
        end

        // four-wire frame end: judge the edge count, then deliver
        cs_rise = c_reg.cs_sync[1] & ~c_reg.cs_prev & c_reg.spi_mode;
        if (cs_rise) begin
            c_next.rb_pending = 1'b0;
            if ((f_reg.count == dsci_pkg::CNT_16) || (f_reg.count == dsci_pkg::CNT_24) ||
                (f_reg.count == dsci_pkg::CNT_32)) begin
                take = ~c_reg.lock;
                word = f_reg.shift[15:0];
            end
        end

        // two-wire edges and bus conditions, ignored in four-wire mode
        if (!c_reg.spi_mode) begin
            scl_rise = c_reg.scl_sync[1] & ~c_reg.scl_prev;
            scl_fall = ~c_reg.scl_sync[1] & c_reg.scl_prev;
            i2c_start = c_reg.scl_sync[1] & c_reg.scl_prev & ~c_reg.sda_sync[1] & c_reg.sda_prev;
            i2c_stop = c_reg.scl_sync[1] & c_reg.scl_prev & c_reg.sda_sync[1] & ~c_reg.sda_prev;
        end

        if (i2c_stop) begin
            // stop always frees the line and ends the transaction
            c_next.ist = dsci_pkg::I2C_IDLE;
            c_next.sda_oe_n = 1'b1;
        end else if (i2c_start) begin
            // start or repeated start: expect an address byte
            c_next.ist = dsci_pkg::I2C_ADDR;
            c_next.bitcnt = 4'hF; // wraps to 0 on start's scl fall
            c_next.sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            // sample data bits, or the host's ack after a sent byte
            if (c_reg.bitcnt != dsci_pkg::BIT_ACK) begin
                c_next.rx = {c_reg.rx[6:0], c_reg.sda_sync[1]};
            end else begin
                c_next.mack = ~c_reg.sda_sync[1];
            end
        end else if (scl_fall) begin
            unique case (c_reg.ist)
                dsci_pkg::I2C_IDLE: begin
                    c_next.sda_oe_n = 1'b1;
                end
                dsci_pkg::I2C_ADDR: begin
                    if (c_reg.bitcnt == dsci_pkg::BIT_LAST) begin
                        c_next.bitcnt = dsci_pkg::BIT_ACK;
                        // only the strapped seven-bit address, never while storing
                        if ((c_reg.rx[7:1] == c_reg.own_addr) && !c_reg.lock) begin
                            c_next.rw = c_reg.rx[0];
                            c_next.sda_oe_n = 1'b0;
                        end else begin
                            c_next.ist = dsci_pkg::I2C_IDLE;
                        end
                    end else if (c_reg.bitcnt == dsci_pkg::BIT_ACK) begin
                        c_next.bitcnt = '0;
                        c_next.half = 1'b0;
                        c_next.tx_lo = 1'b0;
                        if (c_reg.rw) begin
                            // read: first bit of high byte goes out now
                            c_next.ist = dsci_pkg::I2C_READ;
                            c_next.serve = c_reg.rb_pending;
                            c_next.rb_pending = 1'b0;
                            c_next.tx = c_reg.rb_pending ? c_reg.rb_word[15:8]
                                                         : dsci_pkg::BYTE_IDLE;
                            c_next.sda_oe_n = c_reg.rb_pending ? c_reg.rb_word[15]
                                                               : 1'b1;
                        end else begin
                            c_next.ist = dsci_pkg::I2C_WRITE;
                            c_next.sda_oe_n = 1'b1;
                        end
                    end else begin
                        c_next.bitcnt = c_reg.bitcnt + 4'h1;
                    end
                end
                dsci_pkg::I2C_WRITE: begin
                    if (c_reg.bitcnt == dsci_pkg::BIT_LAST) begin
                        c_next.bitcnt = dsci_pkg::BIT_ACK;
                        if (c_reg.lock) begin
                            // interface is down while the store runs
                            c_next.ist = dsci_pkg::I2C_IDLE;
                        end else begin
                            c_next.sda_oe_n = 1'b0;
                            c_next.half = ~c_reg.half;
                            if (c_reg.half) begin
                                take = 1'b1;
                                word = {c_reg.hi_byte, c_reg.rx};
                            end else begin
                                c_next.hi_byte = c_reg.rx;
                            end
                        end
                    end else if (c_reg.bitcnt == dsci_pkg::BIT_ACK) begin
                        c_next.bitcnt = '0;
                        c_next.sda_oe_n = 1'b1;
                    end else begin
                        c_next.bitcnt = c_reg.bitcnt + 4'h1;
                    end
                end
                dsci_pkg::I2C_READ: begin
                    if (c_reg.bitcnt == dsci_pkg::BIT_LAST) begin
                        // host owns the ack slot
                        c_next.bitcnt = dsci_pkg::BIT_ACK;
                        c_next.sda_oe_n = 1'b1;
                    end else if (c_reg.bitcnt == dsci_pkg::BIT_ACK) begin
                        c_next.bitcnt = '0;
                        if (c_reg.mack && !c_reg.tx_lo) begin
                            c_next.tx_lo = 1'b1;
                            c_next.tx = c_reg.serve ? c_reg.rb_word[7:0]
                                                    : dsci_pkg::BYTE_IDLE;
                            c_next.sda_oe_n = c_reg.serve ? c_reg.rb_word[7] : 1'b1;
                        end else begin
                            // nack or both bytes sent: wait for stop
                            c_next.ist = dsci_pkg::I2C_IDLE;
                            c_next.sda_oe_n = 1'b1;
                        end
                    end else begin
                        c_next.bitcnt = c_reg.bitcnt + 4'h1;
                        c_next.tx = {c_reg.tx[6:0], 1'b1};
                        c_next.sda_oe_n = c_reg.tx[6];
                    end
                end
            endcase
        end

        // deliver a command; stores start the lockout
        if (take) begin
            c_next.cmd_word = word;
            c_next.cmd_valid = 1'b1;
            if ((word[dsci_pkg::CODE_MSB:dsci_pkg::CODE_LSB] == dsci_pkg::CODE_EE_WRITE) ||
                ((word[dsci_pkg::CODE_MSB:dsci_pkg::CODE_LSB] == dsci_pkg::CODE_COPY) &&
                 word[0])) begin
                c_next.lock = 1'b1;
                c_next.lock_cnt = LW'(EE_LOCK_CYCLES - 1);
            end
        end

        // readback result arriving wins over any clear this cycle
        if (resp_valid) begin
            c_next.rb_word = resp_word;
            c_next.rb_pending = 1'b1;
        end
    end

    // core registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            c_reg <= '0;
            c_reg.cs_sync <= 2'h3;
            c_reg.cs_prev <= 1'b1;
            c_reg.scl_sync <= 2'h3;
            c_reg.sda_sync <= 2'h3;
            c_reg.scl_prev <= 1'b1;
            c_reg.sda_prev <= 1'b1;
            c_reg.spi_mode <= 1'b1;
            c_reg.ist <= dsci_pkg::I2C_IDLE;
            c_reg.tx <= dsci_pkg::BYTE_IDLE;
            c_reg.sda_oe_n <= 1'b1;
            c_reg.rb_word <= dsci_pkg::WORD_RST;
        end else begin
            c_reg <= c_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign serial_out_od = r_reg.od_level;
    assign serial_out_oe_n = r_reg.oe_n;
    assign sda_out = c_reg.sda_out;
    assign sda_oe_n = c_reg.sda_oe_n;
    assign cmd_word = c_reg.cmd_word;
    assign cmd_valid = c_reg.cmd_valid;
    assign eeprom_lock = c_reg.lock;

endmodule // dsci_top

// *** testbench/dsci_checker.sv ***
// port assertions for the command front end
// assumes one core clock domain; bound onto dsci_top below
module dsci_checker #(
    parameter int unsigned EE_LOCK_CYCLES = dsci_pkg::EE_LOCK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched ports
    input wire logic link_select_strap,
    input wire logic frame_sel_n,
    input wire logic serial_out_oe_n,
    input wire logic scl_in,
    input wire logic sda_oe_n,
    input wire logic cmd_valid,
    input wire logic eeprom_lock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [19:0] lock_cnt; // cycles spent locked
    // lock length counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) lock_cnt <= 20'h00000;
        else lock_cnt <= eeprom_lock ? lock_cnt + 20'h00001 : 20'h00000;
    end
    so_frame_a: assert property (frame_sel_n |-> serial_out_oe_n)
        else $error("data out driven outside frame");
    so_mode_a: assert property (link_select_strap |-> serial_out_oe_n)
        else $error("data out driven in two-wire mode");
    ack_mode_a: assert property (!sda_oe_n |-> link_select_strap)
        else $error("sda driven in four-wire mode");
    ack_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
        else $error("sda moved while scl high");
    valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe too long");
    cmd_after_a: assert property (cmd_valid |-> frame_sel_n && $past(frame_sel_n, 2))
        else $error("command inside a frame");
    lock_block_a: assert property ($past(eeprom_lock) |-> !cmd_valid)
        else $error("command while locked");
    lock_len_a: assert property ($fell(eeprom_lock) |->
        lock_cnt + 1 >= EE_LOCK_CYCLES && lock_cnt <= EE_LOCK_CYCLES + 1)
        else $error("lock length wrong");
endmodule // dsci_checker

bind dsci_top dsci_checker #(.EE_LOCK_CYCLES(EE_LOCK_CYCLES)) i_chk (.clk(clk), .nrst(nrst),
    .link_select_strap(link_select_strap), .frame_sel_n(frame_sel_n),
    .serial_out_oe_n(serial_out_oe_n), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
    .cmd_valid(cmd_valid), .eeprom_lock(eeprom_lock));

// *** testbench/dsci_host.sv ***
// host model: four-wire and two-wire master
// assumes wired-and lines resolved by the bench
module dsci_host (
    // four-wire side
    output logic spi_clk,
    output logic frame_sel_n,
    output logic serial_in,
    input wire logic so_line,
    // two-wire side
    output logic scl,
    output logic sda_h,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HP = 32; // low phase of the 96 ns link clock
    localparam int QP = 625; // quarter of a 400 kHz bit
    initial begin
        {spi_clk, frame_sel_n, serial_in, scl, sda_h} = 5'h1F;
    end
    // n bits msb first; clock idles high, stands still between frames
    task automatic frame(input logic [31:0] d, input int n, output logic [31:0] q);
        q = 32'h00000000;
        #HP frame_sel_n = 1'b0;
        for (int k = n - 1; k >= 0; k--) begin
            serial_in = d[k];
            #HP spi_clk = 1'b0;
            #HP spi_clk = 1'b1;
            #(HP / 2) q = {q[30:0], so_line};
            #(HP / 2);
        end
        frame_sel_n = 1'b1;
        serial_in = ~serial_in; // released line shows no stale bit
    endtask
    // one two-wire bit
    task automatic bit_io(input logic b, output logic r);
        sda_h = b;
        #QP scl = 1'b1;
        #QP r = sda;
        #QP scl = 1'b0;
        #QP;
    endtask
    // byte then acknowledge slot
    task automatic byte_io(input logic [7:0] b, input logic a, output logic [7:0] r,
                           output logic ra);
        for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
        bit_io(a, ra);
    endtask
    task automatic start();
        #QP scl = 1'b1;
        #QP sda_h = 1'b0;
        #QP scl = 1'b0;
    endtask
    task automatic stop();
        sda_h = 1'b0;
        #QP scl = 1'b1;
        #QP sda_h = 1'b1;
        #QP;
    endtask
    // write nb bytes; nk counts refused bytes, address refusal gives 9
    task automatic i2c_wr(input logic [7:0] ab, input logic [31:0] d, input int nb,
                          output int nk);
        logic [7:0] r;
        logic a;
        start();
        byte_io(ab, 1'b1, r, a);
        nk = (a === 1'b0) ? 0 : 9;
        for (int i = nb; i > 0 && nk == 0; i--) begin
            byte_io(d[8 * i - 1 -: 8], 1'b1, r, a);
            nk += (a !== 1'b0);
        end
        stop();
    endtask
    // two-byte read, a1 is host answer to first byte
    task automatic i2c_rd(input logic [7:0] ab, input logic a1, output logic [15:0] r);
        logic a;
        start();
        byte_io(ab, 1'b1, r[15:8], a);
        byte_io(8'hFF, a1, r[15:8], a);
        byte_io(8'hFF, 1'b1, r[7:0], a);
        stop();
    endtask
endmodule // dsci_host

// *** testbench/dsci_top_tb.sv ***
// self-checking bench for dsci_top through the host model
// assumes dsci_host and dsci_checker compiled before it
module dsci_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOCK = 400; // short eeprom lock
    localparam logic [6:0] ADR = 7'h22; // hi strap high, lo strap open
    localparam logic [15:0] RB = 16'hA5C3; // value served on readback
    logic clk, nrst, sel, spi_clk, frame_sel_n, serial_in, scl_in, sda_h, resp_valid;
    logic serial_out_od, serial_out_oe_n, sda_out, sda_oe_n, cmd_valid, eeprom_lock;
    logic [1:0] st_lo, st_hi;
    logic [15:0] cmd_word, resp_word, got, r;
    logic [31:0] sq;
    int bad_count, total_checks, n_cmd, cyc, nk, np;
    wire logic so_line = serial_out_oe_n ? 1'b1 : serial_out_od; // pulled up
    wire logic sda_in = (sda_oe_n ? 1'b1 : sda_out) & sda_h; // pulled up
    dsci_top #(.EE_LOCK_CYCLES(LOCK)) i_dut (.clk(clk), .nrst(nrst), .link_select_strap(sel),
        .address_strap_lo(st_lo), .address_strap_hi(st_hi), .spi_clk(spi_clk),
        .frame_sel_n(frame_sel_n), .serial_in(serial_in), .serial_out_od(serial_out_od),
        .serial_out_oe_n(serial_out_oe_n), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
        .eeprom_lock(eeprom_lock), .resp_word(resp_word), .resp_valid(resp_valid));
    dsci_host i_host (.spi_clk(spi_clk), .frame_sel_n(frame_sel_n), .serial_in(serial_in),
        .so_line(so_line), .scl(scl_in), .sda_h(sda_h), .sda(sda_in));
    initial begin
        forever #50 clk = ~clk;
    end
    // counts strobes, serves readback, cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cmd_valid === 1'b1) begin
            n_cmd++;
            got = cmd_word;
        end
        resp_valid <= (cmd_valid === 1'b1) && (cmd_word[15:12] === 4'h3);
        if (cyc > 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // one frame, expect dv strobes ending with word w
    task automatic spi(input logic [31:0] d, input int n, input int dv, input logic [15:0] w);
        int c0 = n_cmd;
        i_host.frame(d, n, sq);
        repeat (8) @(posedge clk);
        chk(n_cmd - c0 == dv && (dv == 0 || got === w), "four-wire command");
    endtask
    // one write transaction, acked exactly when dv above zero
    task automatic wr(input logic [7:0] ab, input logic [31:0] d, input int nb, input int dv,
                      input logic [15:0] w);
        int c0 = n_cmd;
        i_host.i2c_wr(ab, d, nb, nk);
        repeat (8) @(posedge clk);
        chk(n_cmd - c0 == dv && (dv == 0 || got === w) && (nk == 0) == (dv > 0), "write");
    endtask
    task automatic t_spi();
        spi(32'h1080, 16, 1, 16'h1080);
        spi(32'h1080, 15, 0, 16'h0000);
        spi(32'h12345, 17, 0, 16'h0000);
        spi(32'hAB2345, 24, 1, 16'h2345);
        spi(32'h12342056, 32, 1, 16'h2056);
        chk(sq[16:1] === 16'h1234, "chain pass-through");
        spi(32'h3003, 16, 1, 16'h3003);
        spi(32'h1011, 16, 1, 16'h1011);
        chk(sq[15:0] === RB, "four-wire readback");
        spi(32'h7001, 16, 1, 16'h7001);
        chk(eeprom_lock === 1'b1, "lock on store");
        spi(32'h1022, 16, 0, 16'h0000);
        repeat (LOCK) @(posedge clk);
        spi(32'h1022, 16, 1, 16'h1022);
        $display("four-wire tests done");
    endtask
    task automatic t_i2c();
        sel <= 1'b1;
        repeat (10) @(posedge clk);
        spi(32'h1033, 16, 0, 16'h0000);
        wr({ADR, 1'b0}, 32'h10441055, 4, 2, 16'h1055);
        wr(8'h54, 32'h1066, 2, 0, 16'h0000);
        wr(8'h00, 32'h1066, 2, 0, 16'h0000);
        wr(8'hF0, 32'h1066, 2, 0, 16'h0000);
        wr({ADR, 1'b0}, 32'h3003, 2, 1, 16'h3003);
        i_host.i2c_rd({ADR, 1'b1}, 1'b0, r);
        chk(r === RB, "two-wire readback");
        i_host.i2c_rd({ADR, 1'b1}, 1'b0, r);
        chk(r === 16'hFFFF, "no repeat readback");
        wr({ADR, 1'b0}, 32'h3003, 2, 1, 16'h3003);
        i_host.i2c_rd({ADR, 1'b1}, 1'b1, r);
        chk(r === {RB[15:8], 8'hFF}, "second byte after nack");
        wr({ADR, 1'b0}, 32'h8077, 2, 1, 16'h8077);
        np = 0;
        nk = 9;
        while (nk != 0 && np < 20) begin
            i_host.i2c_wr({ADR, 1'b0}, 32'h0, 0, nk);
            np++;
        end
        chk(np > 1 && nk == 0, "ack polling");
        $display("two-wire tests done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {clk, nrst, sel, resp_valid, bad_count, total_checks, n_cmd, cyc} = '0;
        {st_lo, st_hi, resp_word} = {2'h1, 2'h2, RB};
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        chk(serial_out_oe_n === 1'b1 && sda_oe_n === 1'b1, "lines released");
        t_spi();
        t_i2c();
        final_report();
    end
endmodule // dsci_top_tb
